// ---- rmo_core.sv ----
// Operand address generation and execution for register/memory nibble instructions.
// Assumes instructions come from logic on the same clock, one at a time while idle.
// Summary of operation
// - Register operand: bank and row from pointer, column from r field.
// - Memory operand: bank from bank register, row and column from m field.
// - Add sums register and memory nibbles, result written to the register.
// - Same register addressing for carry ops, subtract, logic, load, store, rotate, indirect.
// - Register stays in the pointer's bank whatever the bank register holds.
// - Indirect transfer destination row equals the m address row, or the indirect row pointer's row when its enable bit is set.
// - Indirect transfer destination column is the register's current content.
// - Rewriting the pointer moves the register window for later instructions.
// - Rotate shifts the register nibble right through carry.
// - Old carry enters bit 3, old bit 0 becomes carry; result stored.
// - Compare-only (add/subtract ops): no store; zero result keeps zero flag, nonzero clears it.
// - Compare-only with decimal clear computes in binary and discards result.
// - Register area is the sixteen nibbles of one memory row.
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module rmo_core
  import rmo_pkg::*;
(
  input  wire logic                  clk,         // Core clock, 10 MHz
  input  wire logic                  arst_n,      // Async reset, active low
  input  wire logic                  instr_valid, // Instruction start pulse
  input  wire rmo_pkg::rmo_op_e      instr_op,    // Opcode
  input  wire logic [rmo_pkg::COL_W-1:0] instr_r, // r operand field
  input  wire logic [rmo_pkg::M_W-1:0]   instr_m, // m operand field
  output logic                       busy_q,      // Instruction in progress
  output logic                       done_q,      // One-cycle completion pulse
  input  wire logic [rmo_pkg::REG_AW-1:0] reg_addr, // Register address
  input  wire logic [rmo_pkg::REG_DW-1:0] reg_wdata, // Register write data
  input  wire logic                  reg_wr,      // Write strobe
  input  wire logic                  reg_rd,      // Read strobe
  output logic [rmo_pkg::REG_DW-1:0] reg_rdata_q  // Read data, cycle after strobe
);
  import rmo_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_RD_R, S_GET_R, S_GET_M, S_GET_I, S_EXEC
  } rmo_state_e;

  rmo_state_e       state_q;
  rmo_op_e          op_q;
  logic [RP_W-1:0]  gr_row_pointer_q;
  logic [BANK_W-1:0] bank_q;
  logic [3:0]       psw_q;
  logic [3:0]       indirect_row_pointer_q;
  logic [MA_W-1:0]  maddr_q;
  logic [MA_W-1:0]  gr_addr_q;
  logic [MA_W-1:0]  dm_addr_q;
  logic [NIB_W-1:0] r_val_q;
  logic [NIB_W-1:0] m_val_q;
  logic [NIB_W-1:0] mem_rdata;
  logic             done_d;

  wire carry_flag        = psw_q[PSW_CY];
  wire compare_only_flag = psw_q[PSW_CMP];
  wire decimal_flag      = psw_q[PSW_BCD];

  // Register window is one row of sixteen nibbles
  wire [MA_W-1:0] gr_addr_w = {gr_row_pointer_q, instr_r};
  wire [MA_W-1:0] dm_addr_w = {bank_q, instr_m};
  wire [ROW_W-1:0] ind_row  = indirect_row_pointer_q[MP_EN] ?
                              indirect_row_pointer_q[ROW_W-1:0] :
                              dm_addr_q[M_W-1:COL_W];
  wire [MA_W-1:0] ind_addr  = {dm_addr_q[MA_W-1:M_W], ind_row, r_val_q};

  wire sw_wr     = reg_wr && (state_q == S_IDLE);
  wire wr_rp     = reg_wr && (reg_addr == REG_RP);
  wire wr_bank   = reg_wr && (reg_addr == REG_BANK);
  wire wr_psw    = reg_wr && (reg_addr == REG_PSW);
  wire wr_mp     = reg_wr && (reg_addr == REG_MP);
  wire wr_maddr  = reg_wr && (reg_addr == REG_MADDR);
  wire wr_mdata  = sw_wr && (reg_addr == REG_MDATA);
  wire is_arith  = (op_q == OP_ADD) || (op_q == OP_ADD_WITH_CARRY) ||
                   (op_q == OP_SUB) || (op_q == OP_SUBTRACT_WITH_BORROW);
  wire is_sub    = (op_q == OP_SUB) || (op_q == OP_SUBTRACT_WITH_BORROW);
  wire use_cy    = ((op_q == OP_ADD_WITH_CARRY) || (op_q == OP_SUBTRACT_WITH_BORROW)) && carry_flag;

  // ALU
  logic [4:0]       raw;
  logic [NIB_W-1:0] res;
  logic             res_cy;
  logic             store;
  logic [MA_W-1:0]  dst_addr;
  logic [3:0]       psw_d;

  always_comb begin
    raw = 5'h00;
    if (is_sub) begin
      raw = {1'b0, r_val_q} - {1'b0, m_val_q} - {4'h0, use_cy};
    end else begin
      raw = {1'b0, r_val_q} + {1'b0, m_val_q} + {4'h0, use_cy};
    end
    res_cy = raw[4];
    res    = raw[3:0];
    // Decimal correction only when the decimal flag is set
    if (decimal_flag && !is_sub && (raw > BCD_MAX)) begin
      raw    = raw + BCD_ADJ;
      res    = raw[3:0];
      res_cy = 1'b1;
    end else if (decimal_flag && is_sub && res_cy) begin
      raw = raw - BCD_ADJ;
      res = raw[3:0];
    end
    store    = 1'b1;
    dst_addr = gr_addr_q;
    psw_d    = psw_q;
    unique case (op_q)
      OP_ADD, OP_ADD_WITH_CARRY, OP_SUB, OP_SUBTRACT_WITH_BORROW: begin
        store           = !compare_only_flag;
        psw_d[PSW_CY]   = res_cy;
        psw_d[PSW_Z]    = (res == 4'h0) ? (compare_only_flag ? psw_q[PSW_Z] : 1'b1)
                                        : 1'b0;
      end
      OP_AND: res = r_val_q & m_val_q;
      OP_OR:  res = r_val_q | m_val_q;
      OP_XOR: res = r_val_q ^ m_val_q;
      OP_LD:  res = m_val_q;
      OP_ST: begin
        res      = r_val_q;
        dst_addr = dm_addr_q;
      end
      OP_MOV_TO_IND: begin
        res      = m_val_q;
        dst_addr = ind_addr;
      end
      OP_MOV_FROM_IND: begin
        res      = m_val_q;
        dst_addr = dm_addr_q;
      end
      OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        res           = {carry_flag, r_val_q[3:1]};
        psw_d[PSW_CY] = r_val_q[0];
      end
      default: store = 1'b0;
    endcase
  end

  // Memory port selection
  wire exec_we = (state_q == S_EXEC) && store;
  wire mem_we  = exec_we || wr_mdata;
  wire [MA_W-1:0] mem_waddr = exec_we ? dst_addr : maddr_q;
  wire [NIB_W-1:0] mem_wdata = exec_we ? res : reg_wdata[NIB_W-1:0];
  wire [MA_W-1:0] mem_raddr = (state_q == S_RD_R)  ? gr_addr_q :
                              (state_q == S_GET_R) ? dm_addr_q :
                              (state_q == S_GET_M) ? ind_addr  : maddr_q;

  rmo_mem #(
    .AW (MA_W),
    .DW (NIB_W)
  ) u_mem (
    .clk     (clk),
    .arst_n  (arst_n),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr   (mem_raddr),
    .rdata_q (mem_rdata)
  );

  // Sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q   <= S_IDLE;
      op_q      <= OP_ADD;
      gr_addr_q <= '0;
      dm_addr_q <= '0;
      r_val_q   <= '0;
      m_val_q   <= '0;
    end else begin
      unique case (state_q)
        S_IDLE: if (instr_valid) begin
          op_q      <= instr_op;
          gr_addr_q <= gr_addr_w;
          dm_addr_q <= dm_addr_w;
          state_q   <= S_RD_R;
        end
        S_RD_R:  state_q <= S_GET_R;
        S_GET_R: begin
          r_val_q <= mem_rdata;
          state_q <= S_GET_M;
        end
        S_GET_M: begin
          m_val_q <= mem_rdata;
          state_q <= (op_q == OP_MOV_FROM_IND) ? S_GET_I : S_EXEC;
        end
        S_GET_I: begin
          m_val_q <= mem_rdata;
          state_q <= S_EXEC;
        end
        S_EXEC:  state_q <= S_IDLE;
      endcase
    end
  end

  assign done_d = (state_q == S_EXEC);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      busy_q <= (state_q == S_IDLE) ? instr_valid : !done_d;
      done_q <= done_d;
    end
  end

  // Software registers; the engine's flag update wins over a software write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gr_row_pointer_q       <= RP_RST;
      bank_q                 <= BANK_RST;
      psw_q                  <= PSW_RST;
      indirect_row_pointer_q <= MP_RST;
      maddr_q                <= '0;
    end else begin
      if (wr_rp) begin
        gr_row_pointer_q <= reg_wdata[RP_W-1:0];
      end
      if (wr_bank) begin
        bank_q <= reg_wdata[BANK_W-1:0];
      end
      if (done_d) begin
        psw_q <= psw_d;
      end else if (wr_psw) begin
        psw_q <= reg_wdata[3:0];
      end
      if (wr_mp) begin
        indirect_row_pointer_q <= reg_wdata[3:0];
      end
      if (wr_maddr) begin
        maddr_q <= reg_wdata[MA_W-1:0];
      end
    end
  end

  // Read data
  logic [REG_DW-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      REG_RP:    rd_mux = {{(REG_DW-RP_W){1'b0}}, gr_row_pointer_q};
      REG_BANK:  rd_mux = {{(REG_DW-BANK_W){1'b0}}, bank_q};
      REG_PSW:   rd_mux = {12'h000, psw_q};
      REG_MP:    rd_mux = {12'h000, indirect_row_pointer_q};
      REG_MADDR: rd_mux = {{(REG_DW-MA_W){1'b0}}, maddr_q};
      REG_MDATA: rd_mux = {12'h000, mem_rdata};
      REG_STAT:  rd_mux = {15'h0000, busy_q};
      default:   rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end else begin
      reg_rdata_q <= '0;
    end
  end
endmodule

// ---- rmo_core_props.sv ----
// Checker for rmo_core: instruction timing and register readback.
// Assumes it is bound to rmo_core and sees only its ports.
`timescale 1ns/1ns
module rmo_core_props
  import rmo_pkg::*;
(
  input wire logic                   clk,         // Core clock
  input wire logic                   arst_n,      // Async reset
  input wire logic                   instr_valid, // Start pulse
  input wire rmo_pkg::rmo_op_e       instr_op,    // Opcode
  input wire logic                   busy_q,      // Busy level
  input wire logic                   done_q,      // Done pulse
  input wire logic [REG_AW-1:0]      reg_addr,    // Register address
  input wire logic [REG_DW-1:0]      reg_wdata,   // Write data
  input wire logic                   reg_wr,      // Write strobe
  input wire logic                   reg_rd,      // Read strobe
  input wire logic [REG_DW-1:0]      reg_rdata_q  // Read data
);
  logic [15:0] rp_q;
  logic [15:0] bank_q;
  logic [15:0] mp_q;
  wire start = instr_valid && !busy_q && instr_op != OP_MOV_FROM_IND;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rp_q <= 16'h0000;
      bank_q <= 16'h0000;
      mp_q <= 16'h0000;
    end else if (reg_wr) begin
      if (reg_addr == REG_RP) rp_q <= {9'h000, reg_wdata[6:0]};
      if (reg_addr == REG_BANK) bank_q <= {12'h000, reg_wdata[3:0]};
      if (reg_addr == REG_MP) mp_q <= {12'h000, reg_wdata[3:0]};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_busy_span: assert property (start |=> busy_q [*4] ##1 (!busy_q && done_q))
    else $error("busy or done timing wrong");
  a_done_pulse: assert property (done_q |=> !done_q)
    else $error("done longer than one cycle");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata_q == 16'h0000)
    else $error("read data not zero");
  a_ptr_back: assert property (reg_rd && reg_addr == REG_RP |=> reg_rdata_q == $past(rp_q))
    else $error("pointer readback wrong");
  a_bank_back: assert property (reg_rd && reg_addr == REG_BANK |=> reg_rdata_q == $past(bank_q))
    else $error("bank readback wrong");
  a_mp_back: assert property (reg_rd && reg_addr == REG_MP |=> reg_rdata_q == $past(mp_q))
    else $error("indirect pointer readback wrong");
  a_hole_zero: assert property (reg_rd && reg_addr == 3'h7 |=> reg_rdata_q == 16'h0000)
    else $error("unmapped read not zero");
  a_stat_busy: assert property (reg_rd && reg_addr == REG_STAT
    |=> reg_rdata_q == {15'h0000, $past(busy_q)})
    else $error("status busy bit wrong");
endmodule
bind rmo_core rmo_core_props rmo_core_props_inst (.clk(clk), .arst_n(arst_n),
  .instr_valid(instr_valid), .instr_op(instr_op), .busy_q(busy_q), .done_q(done_q),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q));

// ---- rmo_core_tb_top.sv ----
// Testbench for rmo_core: register bus tasks and instruction sequences.
// Assumes rmo_prog_src feeds instructions and the checker binds itself.
`timescale 1ns/1ns
module rmo_core_tb_top;
  import rmo_pkg::*;
  localparam logic [10:0] ra = 11'h0A4;
  localparam logic [10:0] ma = 11'h1D6;
  logic clk = 1'b0, arst_n = 1'b0, go = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  rmo_op_e op = OP_ADD;
  logic [COL_W-1:0] r = '0;
  logic [M_W-1:0] m = '0;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [REG_DW-1:0] reg_wdata = '0;
  logic instr_valid, busy_q, done_q;
  rmo_op_e instr_op;
  logic [COL_W-1:0] instr_r;
  logic [M_W-1:0] instr_m;
  logic [REG_DW-1:0] reg_rdata_q;
  int errors = 0, checked = 0, cycles = 0;
  always #50 clk = ~clk;
  rmo_prog_src rmo_prog_src_inst (.clk(clk), .arst_n(arst_n), .go(go), .op(op), .r(r), .m(m),
    .busy_q(busy_q), .instr_op(instr_op), .instr_r(instr_r), .instr_m(instr_m),
    .instr_valid(instr_valid));
  rmo_core rmo_core_inst (.clk(clk), .arst_n(arst_n), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_r(instr_r), .instr_m(instr_m), .busy_q(busy_q),
    .done_q(done_q), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
  task automatic finish_test();
    $display("checked %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] e);
    checked++;
    if (got !== e) begin
      errors++;
      $display("unexpected at %0t: got %h, want %h", $time, got, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_q, e);
  endtask
  task automatic mw(input logic [10:0] a, input logic [3:0] d);
    wr(REG_MADDR, {5'h00, a});
    wr(REG_MDATA, {12'h000, d});
  endtask
  task automatic mchk(input logic [10:0] a, input logic [3:0] e);
    wr(REG_MADDR, {5'h00, a});
    repeat (2) @(posedge clk);
    rd(REG_MDATA, {12'h000, e});
  endtask
  task automatic run(input rmo_op_e o, input logic [3:0] rr, input logic [6:0] mm);
    int n;
    @(posedge clk);
    go <= 1'b1;
    op <= o;
    r <= rr;
    m <= mm;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    chk({15'h0000, busy_q}, 16'h0001);
    for (n = 0; n < 20 && done_q !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk({15'h0000, done_q}, 16'h0001);
  endtask
  task automatic step(input rmo_op_e o, input logic [3:0] f, mv, e, ef);
    wr(REG_PSW, {12'h000, f});
    mw(ma, mv);
    run(o, 4'h4, 7'h56);
    mchk(o == OP_ST ? ma : ra, e);
    rd(REG_PSW, {12'h000, ef});
    $display("step %0d done", o);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 8; i++) if (i != 5) rd(3'(i), 16'h0000);
    wr(REG_RP, 16'hFF8A);
    rd(REG_RP, 16'h000A);
    wr(REG_BANK, 16'hFFF3);
    rd(REG_BANK, 16'h0003);
    wr(REG_MP, 16'hFFF0);
    rd(REG_MP, 16'h0000);
    wr(3'h7, 16'hFFFF);
    rd(3'h7, 16'h0000);
    mw(ra, 4'h5);
    step(OP_ADD, 4'h0, 4'h7, 4'hC, 4'h0);
    step(OP_ADD_WITH_CARRY, 4'h2, 4'h7, 4'h4, 4'h2);
    step(OP_SUB, 4'h0, 4'h5, 4'hF, 4'h2);
    step(OP_SUBTRACT_WITH_BORROW, 4'h2, 4'h3, 4'hB, 4'h0);
    step(OP_ROTATE_RIGHT_THROUGH_CARRY, 4'h2, 4'h0, 4'hD, 4'h2);
    step(OP_SUB, 4'h5, 4'h3, 4'hD, 4'h4);
    step(OP_SUB, 4'h5, 4'hD, 4'hD, 4'h5);
    step(OP_AND, 4'h0, 4'h6, 4'h4, 4'h0);
    step(OP_OR, 4'h0, 4'h3, 4'h7, 4'h0);
    step(OP_XOR, 4'h0, 4'h5, 4'h2, 4'h0);
    step(OP_ADD, 4'h8, 4'h9, 4'h1, 4'hA);
    step(OP_SUB, 4'h8, 4'h3, 4'h8, 4'hA);
    step(OP_LD, 4'h0, 4'h9, 4'h9, 4'h0);
    step(OP_ST, 4'h0, 4'h0, 4'h9, 4'h0);
    mw(11'h1D2, 4'hE);
    run(OP_MOV_TO_IND, 4'h4, 7'h52);
    mchk(11'h1D9, 4'hE);
    mw(11'h1D3, 4'h1);
    run(OP_MOV_FROM_IND, 4'h4, 7'h53);
    mchk(11'h1D3, 4'hE);
    wr(REG_MP, 16'h000E);
    run(OP_MOV_TO_IND, 4'h4, 7'h52);
    mchk(11'h1E9, 4'hE);
    wr(REG_RP, 16'h000B);
    mw(11'h0B4, 4'h3);
    run(OP_LD, 4'h4, 7'h52);
    mchk(11'h0B4, 4'hE);
    mchk(ra, 4'h9);
    $display("indirect and pointer tests done");
    finish_test();
  end
endmodule

// ---- rmo_mem.sv ----
// Shared constants for the register/memory operand engine, and its nibble data memory.
// Assumes one clock; memory contents are not reset, only the read register is.
package rmo_pkg;
  localparam int BANK_W = 4;
  localparam int ROW_W  = 3;
  localparam int COL_W  = 4;
  localparam int NIB_W  = 4;
  localparam int M_W    = ROW_W + COL_W;
  localparam int RP_W   = BANK_W + ROW_W;
  localparam int MA_W   = BANK_W + M_W;
  localparam int REG_AW = 3;
  localparam int REG_DW = 16;
  // Register offsets
  localparam logic [REG_AW-1:0] REG_RP    = 3'h0;
  localparam logic [REG_AW-1:0] REG_BANK  = 3'h1;
  localparam logic [REG_AW-1:0] REG_PSW   = 3'h2;
  localparam logic [REG_AW-1:0] REG_MP    = 3'h3;
  localparam logic [REG_AW-1:0] REG_MADDR = 3'h4;
  localparam logic [REG_AW-1:0] REG_MDATA = 3'h5;
  localparam logic [REG_AW-1:0] REG_STAT  = 3'h6;
  // Flag word field positions
  localparam int PSW_Z   = 0;
  localparam int PSW_CY  = 1;
  localparam int PSW_CMP = 2;
  localparam int PSW_BCD = 3;
  // Indirect row pointer: row in low bits, enable above
  localparam int MP_EN   = 3;
  // Reset values
  localparam logic [RP_W-1:0]   RP_RST   = 7'h00;
  localparam logic [BANK_W-1:0] BANK_RST = 4'h0;
  localparam logic [3:0]        PSW_RST  = 4'h0;
  localparam logic [3:0]        MP_RST   = 4'h0;
  // Decimal correction constants
  localparam logic [4:0] BCD_MAX = 5'h09;
  localparam logic [4:0] BCD_ADJ = 5'h06;
  typedef enum logic [3:0] {
    OP_ADD, OP_ADD_WITH_CARRY, OP_SUB, OP_SUBTRACT_WITH_BORROW, OP_AND, OP_OR, OP_XOR,
    OP_LD, OP_ST, OP_MOV_TO_IND, OP_MOV_FROM_IND, OP_ROTATE_RIGHT_THROUGH_CARRY
  } rmo_op_e;
endpackage

`timescale 1ns/1ns
module rmo_mem #(
  parameter int AW = 11,
  parameter int DW = 4
) (
  input  wire logic          clk,     // Core clock
  input  wire logic          arst_n,  // Async reset, active low
  input  wire logic          we,      // Write strobe
  input  wire logic [AW-1:0] waddr,   // Write address
  input  wire logic [DW-1:0] wdata,   // Write data
  input  wire logic [AW-1:0] raddr,   // Read address
  output logic      [DW-1:0] rdata_q  // Read data, one cycle later
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem[raddr];
    end
  end
endmodule

// ---- rmo_prog_src.sv ----
// Instruction source model: issues one instruction when asked, only while idle.
// Assumes the core's clock, reset and busy flag; r and m fields toggle while go is low, the opcode holds.
`timescale 1ns/1ns
module rmo_prog_src
  import rmo_pkg::*;
(
  input  wire logic              clk,         // Core clock
  input  wire logic              arst_n,      // Async reset
  input  wire logic              go,          // Issue request
  input  wire rmo_pkg::rmo_op_e  op,          // Opcode to issue
  input  wire logic [COL_W-1:0]  r,           // r field to issue
  input  wire logic [M_W-1:0]    m,           // m field to issue
  input  wire logic              busy_q,      // Core busy
  output rmo_pkg::rmo_op_e       instr_op,    // Opcode to core
  output logic [COL_W-1:0]       instr_r,     // r field to core
  output logic [M_W-1:0]         instr_m,     // m field to core
  output logic                   instr_valid  // Start pulse to core
);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      instr_valid <= 1'b0;
      instr_op <= OP_ADD;
      instr_r <= '0;
      instr_m <= '0;
    end else begin
      instr_valid <= go && !busy_q && !instr_valid;
      instr_op <= go ? op : instr_op;
      instr_r <= go ? r : ~instr_r;
      instr_m <= go ? m : ~instr_m;
    end
  end
endmodule
